// file: core/ubp_baud.sv
// Fractional baud pre-scaler producing the oversampling tick.
`timescale 1ns/1ps
module ubp_baud (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic run,
	input wire logic [15:0] divisor,
	input wire logic [3:0] prescale_multiplier,
	input wire logic [3:0] prescale_divisor_add,
	output logic tick
);

	logic [15:0] cnt;
	logic [4:0] acc;
	wire [15:0] reload = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
	wire [4:0] mul = {1'b0, prescale_multiplier} + 5'h01;
	wire [4:0] acc_sum = acc + {1'b0, prescale_divisor_add};
	wire frac_on = (prescale_divisor_add != 4'h0);
	// A stretched period adds one whole divisor period without a tick, so the rate scales by mul/(mul+add).
	// The stretched period itself adds nothing to the accumulator, so add periods are inserted per mul ticks.
	wire stretch = frac_on && (acc >= mul);

	// ------------------------------------------------------------
	// Divisor counter and fractional accumulator
	// ------------------------------------------------------------
	// The bus clock is the only clock of the pre-scaler; a zero add field bypasses the accumulator.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cnt <= 16'h0000;
			acc <= 5'h00;
			tick <= 1'b0;
		end else if (!run) begin
			cnt <= 16'h0000;
			acc <= 5'h00;
			tick <= 1'b0;
		end else if (cnt == 16'h0000) begin
			cnt <= reload;
			acc <= stretch ? acc - mul : (frac_on ? acc_sum : 5'h00);
			tick <= !stretch;
		end else begin
			cnt <= cnt - 16'h0001;
			tick <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_frac_bypass: assert property ((run && cnt == 16'h0000 && !frac_on) |=> tick)
		else $error("integer divisor period ended without tick while fraction bypassed");
	a_frac_stretch: assert property ((run && cnt == 16'h0000 && stretch) |=> !tick)
		else $error("stretched period produced a tick");

endmodule

// file: core/ubp_pkg.sv
// Types shared by the baud pre-scaler slice.
package ubp_pkg;

	// One-hot states of the transmit shifter.
	typedef enum logic [3:0] {
		UBP_TX_IDLE = 4'h1,
		UBP_TX_START = 4'h2,
		UBP_TX_DATA = 4'h4,
		UBP_TX_STOP = 4'h8
	} ubp_tx_state_t;

	// One-hot states of the receive shifter.
	typedef enum logic [3:0] {
		UBP_RX_IDLE = 4'h1,
		UBP_RX_START = 4'h2,
		UBP_RX_DATA = 4'h4,
		UBP_RX_STOP = 4'h8
	} ubp_rx_state_t;

endpackage

// file: core/ubp_regs.svh
// Register offsets, field positions, reset values and counts of the baud pre-scaler slice.
`ifndef UBP_REGS_SVH
`define UBP_REGS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define UBP_OFS_FD 8'h28
`define UBP_OFS_CTRL 8'h30
`define UBP_OFS_HALF_DUPLEX_SELECT 8'h34
`define UBP_OFS_DIV 8'h38
`define UBP_OFS_THR 8'h3C
`define UBP_OFS_STAT 8'h40

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define UBP_FD_OVERSAMPLE_BY_EIGHT 8
`define UBP_CTRL_TRANSMIT_ENABLE 7
`define UBP_CTRL_RECEIVE_ENABLE 6
`define UBP_CTRL_PEN 0

// ------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------
`define UBP_FD_RST 9'h000
`define UBP_TRANSMIT_ENABLE_RST 1'h1
`define UBP_RECEIVE_ENABLE_RST 1'h1
`define UBP_DIV_RST 16'h0001
`define UBP_OS16_MAX 4'hF
`define UBP_OS8_MAX 4'h7
`define UBP_LAST_BIT 3'h7

`endif

// file: core/ubp_top.sv
// AHB-Lite serial port slice with fractional baud pre-scaler, enables and half-duplex lock.
//
// Contract
// - Baud clock is derived from the bus clock through the fractional pre-scaler.
// - Default sixteen ticks per bit for both sampling and sending.
// - oversample_by_eight 0 gives sixteen, 1 gives eight; resets to 0.
// - Multiplier is prescale_multiplier plus one, range one to sixteen.
// - Zero prescale_divisor_add bypasses fractional division entirely.
// - transmit_enable low blocks moving the holding byte into the shifter.
// - Clearing transmit_enable mid-character finishes it, then sends nothing more.
// - transmit_enable resets high; queued data goes out once earlier data is done.
// - receive_enable low disables reception; resets high.
// - port_enable low leaves pins as GPIO; high hands them to the port.
// - After reset transmitter and receiver run independently, full-duplex.
// - half_duplex_select locks receiver when idle or after current character.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "ubp_regs.svh"
module ubp_top (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic pin_func_sel
);

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic [8:0] fd;
	logic transmit_enable;
	logic receive_enable;
	logic [2:0] mode;
	logic half_duplex_select;
	logic [15:0] divisor;
	logic [7:0] transmit_holding;
	logic th_valid;
	logic [7:0] rx_data;
	logic rx_valid;
	logic wr_q;
	logic [7:0] addr_q;

	wire oversample_by_eight = fd[`UBP_FD_OVERSAMPLE_BY_EIGHT];
	wire [3:0] prescale_multiplier = fd[7:4];
	wire [3:0] prescale_divisor_add = fd[3:0];
	wire [3:0] os_max = oversample_by_eight ? `UBP_OS8_MAX : `UBP_OS16_MAX;
	wire [3:0] os_half = {1'b0, os_max[3:1]};
	wire tick;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	// Size is not checked: only whole-word transfers are expected, and a narrow one acts as a word.
	wire take = hsel && hready && htrans[1];
	wire rd_take = take && !hwrite;
	wire [7:0] a_ofs = {haddr[7:2], 2'b00};
	wire [7:0] w_ofs = addr_q;
	wire w_fd = wr_q && (w_ofs == `UBP_OFS_FD);
	wire w_ctrl = wr_q && (w_ofs == `UBP_OFS_CTRL);
	wire w_half_duplex_select = wr_q && (w_ofs == `UBP_OFS_HALF_DUPLEX_SELECT);
	wire w_div = wr_q && (w_ofs == `UBP_OFS_DIV);
	wire w_thr = wr_q && (w_ofs == `UBP_OFS_THR);
	wire rd_stat = rd_take && (a_ofs == `UBP_OFS_STAT) && (haddr[31:8] == 24'h000000);

	ubp_pkg::ubp_tx_state_t tx_state;
	ubp_pkg::ubp_rx_state_t rx_state;

	wire tx_busy = (tx_state != ubp_pkg::UBP_TX_IDLE);
	wire rx_busy = (rx_state != ubp_pkg::UBP_RX_IDLE);
	wire [31:0] stat_word = {16'h0000, rx_data, 4'h0, rx_busy, tx_busy, th_valid, rx_valid};
	// Unmapped offsets read as zero; the transmit holding offset is write-only.
	wire [31:0] rd_mux =
		(haddr[31:8] != 24'h000000) ? 32'h00000000 :
		(a_ofs == `UBP_OFS_FD) ? {23'h000000, fd} :
		(a_ofs == `UBP_OFS_CTRL) ? {24'h000000, transmit_enable, receive_enable, 2'h0, mode, pin_func_sel} :
		(a_ofs == `UBP_OFS_HALF_DUPLEX_SELECT) ? {31'h00000000, half_duplex_select} :
		(a_ofs == `UBP_OFS_DIV) ? {16'h0000, divisor} :
		(a_ofs == `UBP_OFS_STAT) ? stat_word : 32'h00000000;

	// Address phase is latched so the write lands in the data phase; the slave never waits.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wr_q <= 1'b0;
			addr_q <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			wr_q <= take && hwrite && (haddr[31:8] == 24'h000000);
			addr_q <= a_ofs;
			hreadyout <= 1'b1;
			if (rd_take) begin
				hrdata <= rd_mux;
			end
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// pin_func_sel is the port enable bit itself, so the pin mux follows it straight from the flop.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			fd <= `UBP_FD_RST;
			transmit_enable <= `UBP_TRANSMIT_ENABLE_RST;
			receive_enable <= `UBP_RECEIVE_ENABLE_RST;
			mode <= 3'h0;
			pin_func_sel <= 1'b0;
			half_duplex_select <= 1'b0;
			divisor <= `UBP_DIV_RST;
		end else begin
			if (w_fd) begin
				fd <= hwdata[8:0];
			end
			if (w_ctrl) begin
				transmit_enable <= hwdata[`UBP_CTRL_TRANSMIT_ENABLE];
				receive_enable <= hwdata[`UBP_CTRL_RECEIVE_ENABLE];
				mode <= hwdata[3:1];
				pin_func_sel <= hwdata[`UBP_CTRL_PEN];
			end
			if (w_half_duplex_select) begin
				half_duplex_select <= hwdata[0];
			end
			if (w_div) begin
				divisor <= hwdata[15:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Baud generation
	// ------------------------------------------------------------
	ubp_baud u_baud (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.run(pin_func_sel),
		.divisor(divisor),
		.prescale_multiplier(prescale_multiplier),
		.prescale_divisor_add(prescale_divisor_add),
		.tick(tick)
	);

	// ------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------
	logic [3:0] tx_os;
	logic [7:0] tx_shift;
	logic [2:0] tx_bit;
	wire tx_bit_done = tick && (tx_os == os_max);
	// The enable is looked at only in idle, so a character already started always completes unless pin_func_sel is cleared.
	wire tx_load = (tx_state == ubp_pkg::UBP_TX_IDLE) && th_valid && transmit_enable && pin_func_sel;

	// A holding write while the byte is still queued is dropped; software polls the full bit first.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			transmit_holding <= 8'h00;
			th_valid <= 1'b0;
		end else if (w_thr && !th_valid) begin
			transmit_holding <= hwdata[7:0];
			th_valid <= 1'b1;
		end else if (tx_load) begin
			th_valid <= 1'b0;
		end
	end

	// Start, eight data bits LSB first, one stop bit; each bit lasts os_max+1 ticks.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tx_state <= ubp_pkg::UBP_TX_IDLE;
			tx_os <= 4'h0;
			tx_shift <= 8'h00;
			tx_bit <= 3'h0;
			serial_out_pin <= 1'b1;
		end else if (!pin_func_sel) begin
			tx_state <= ubp_pkg::UBP_TX_IDLE;
			serial_out_pin <= 1'b1;
		end else begin
			tx_os <= (tx_load || tx_bit_done) ? 4'h0 : (tick && tx_busy) ? tx_os + 4'h1 : tx_os;
			case (tx_state)
				ubp_pkg::UBP_TX_IDLE: begin
					serial_out_pin <= 1'b1;
					if (tx_load) begin
						tx_shift <= transmit_holding;
						serial_out_pin <= 1'b0;
						tx_state <= ubp_pkg::UBP_TX_START;
					end
				end
				ubp_pkg::UBP_TX_START: begin
					if (tx_bit_done) begin
						serial_out_pin <= tx_shift[0];
						tx_shift <= {1'b0, tx_shift[7:1]};
						tx_bit <= 3'h0;
						tx_state <= ubp_pkg::UBP_TX_DATA;
					end
				end
				ubp_pkg::UBP_TX_DATA: begin
					if (tx_bit_done) begin
						tx_bit <= tx_bit + 3'h1;
						if (tx_bit == `UBP_LAST_BIT) begin
							serial_out_pin <= 1'b1;
							tx_state <= ubp_pkg::UBP_TX_STOP;
						end else begin
							serial_out_pin <= tx_shift[0];
							tx_shift <= {1'b0, tx_shift[7:1]};
						end
					end
				end
				ubp_pkg::UBP_TX_STOP: begin
					if (tx_bit_done) begin
						tx_state <= ubp_pkg::UBP_TX_IDLE;
					end
				end
				default: begin
					tx_state <= ubp_pkg::UBP_TX_IDLE;
					serial_out_pin <= 1'b1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------
	logic [3:0] rx_os;
	logic [7:0] rx_shift;
	logic [2:0] rx_bit;
	// Half duplex only blocks a new start; a character already begun runs to its stop bit.
	wire rx_start_ok = receive_enable && pin_func_sel && !half_duplex_select;
	wire rx_mid = tick && (rx_os == os_half);
	wire rx_end = tick && (rx_os == os_max);
	wire rx_store = (rx_state == ubp_pkg::UBP_RX_STOP) && rx_end && serial_in_pin && receive_enable;

	// Received byte flag: a new byte arriving with the status read still sets it.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
		end else if (rx_store) begin
			rx_valid <= 1'b1;
			rx_data <= rx_shift;
		end else if (rd_stat) begin
			rx_valid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rx_state <= ubp_pkg::UBP_RX_IDLE;
			rx_os <= 4'h0;
			rx_shift <= 8'h00;
			rx_bit <= 3'h0;
		end else if (!receive_enable || !pin_func_sel) begin
			rx_state <= ubp_pkg::UBP_RX_IDLE;
			rx_os <= 4'h0;
		end else begin
			rx_os <= tick ? rx_os + 4'h1 : rx_os;
			case (rx_state)
				ubp_pkg::UBP_RX_IDLE: begin
					rx_os <= 4'h0;
					if (rx_start_ok && !serial_in_pin) begin
						rx_state <= ubp_pkg::UBP_RX_START;
					end
				end
				ubp_pkg::UBP_RX_START: begin
					// Re-check the start bit at mid-bit to reject glitches, then sample on bit centres.
					if (rx_mid) begin
						rx_os <= 4'h0;
						rx_bit <= 3'h0;
						rx_state <= serial_in_pin ? ubp_pkg::UBP_RX_IDLE : ubp_pkg::UBP_RX_DATA;
					end
				end
				ubp_pkg::UBP_RX_DATA: begin
					if (rx_end) begin
						rx_os <= 4'h0;
						rx_shift <= {serial_in_pin, rx_shift[7:1]};
						rx_bit <= rx_bit + 3'h1;
						if (rx_bit == `UBP_LAST_BIT) begin
							rx_state <= ubp_pkg::UBP_RX_STOP;
						end
					end
				end
				ubp_pkg::UBP_RX_STOP: begin
					if (rx_end) begin
						rx_os <= 4'h0;
						rx_state <= ubp_pkg::UBP_RX_IDLE;
					end
				end
				default: begin
					rx_state <= ubp_pkg::UBP_RX_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_tx_ready;
		tx_state == ubp_pkg::UBP_TX_IDLE && th_valid && pin_func_sel;
	endsequence

	a_tx_blocked: assert property ((s_tx_ready and !transmit_enable) |=> tx_state == ubp_pkg::UBP_TX_IDLE && th_valid)
		else $error("holding byte moved to shifter while transmit disabled");
	a_tx_launch: assert property ((s_tx_ready and transmit_enable) |=> !serial_out_pin && !th_valid)
		else $error("queued byte not launched with start bit");
	a_tx_finish: assert property ((tx_state == ubp_pkg::UBP_TX_DATA && !transmit_enable && pin_func_sel)
		|=> tx_state inside {ubp_pkg::UBP_TX_DATA, ubp_pkg::UBP_TX_STOP})
		else $error("character aborted when transmit disabled");
	a_os_period: assert property ((tx_busy && pin_func_sel && !tx_bit_done) |=> $stable(serial_out_pin))
		else $error("serial bit changed before its oversampled period ended");
	a_os_wrap: assert property ((tx_busy && tx_bit_done) |=> tx_os == 4'h0)
		else $error("oversample counter did not restart at bit end");
	a_rx_off: assert property (!receive_enable |=> rx_state == ubp_pkg::UBP_RX_IDLE)
		else $error("receiver active while receive disabled");
	a_rx_duplex: assert property ((rx_state == ubp_pkg::UBP_RX_IDLE && rx_start_ok && !serial_in_pin)
		|=> rx_state == ubp_pkg::UBP_RX_START)
		else $error("receiver missed start bit in full duplex");
	a_hd_lock: assert property ((rx_state == ubp_pkg::UBP_RX_IDLE && half_duplex_select) |=> !rx_busy)
		else $error("receiver started while half duplex locked");
	a_gpio_idle: assert property (!pin_func_sel |=> serial_out_pin && !tx_busy)
		else $error("serial output active while pins belong to GPIO");

endmodule

// file: tb/uart_baud_prescale_and_ctrl_tb.sv
// Self-checking bench for the serial port slice, driven over AHB-Lite.
`timescale 1ns/1ps
`include "ubp_regs.svh"
`define UBP_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR %0t: value %h expected %h", $time, g, e); end end
module uart_baud_prescale_and_ctrl_tb;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hrdata;
	logic [31:0] rv;
	logic hreadyout;
	logic hresp;
	logic serial_in_pin;
	logic serial_out_pin;
	logic pin_func_sel;
	int error_cnt = 0;
	int checks_done = 0;
	logic [31:0] fd_tab[5] = '{32'h000, 32'h100, 32'h0F0, 32'h011, 32'h1F1};
	int bc_tab[5] = '{64, 32, 64, 96, 34};

	ubp_top u_dut (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hreadyout(hreadyout),
		.hrdata(hrdata),
		.hresp(hresp),
		.serial_in_pin(serial_in_pin),
		.serial_out_pin(serial_out_pin),
		.pin_func_sel(pin_func_sel)
	);

	ubp_remote u_far (
		.clk_sys(clk_sys),
		.line_in(serial_out_pin),
		.line_out(serial_in_pin)
	);

	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	// Both tasks hold the address phase until hready is seen high, then the data phase likewise.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= 1'b1;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= 1'b0;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		d = hrdata;
		`UBP_CHK(hresp, 1'b0)
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		`UBP_CHK(d, e)
	endtask

	// ------------------------------------------------------------
	// Serial helpers
	// ------------------------------------------------------------
	// The wait is bounded so a silent transmitter shows up as a mismatch, not a hang.
	task automatic wait_q(input int n);
		for (int k = 0; k < 30000 && u_far.got_q.size() < n; k++) @(posedge clk_sys);
	endtask

	task automatic pop_chk(input logic [7:0] e);
		logic [7:0] g;
		wait_q(1);
		g = (u_far.got_q.size() > 0) ? u_far.got_q.pop_front() : 8'hXX;
		`UBP_CHK(g, e)
	endtask

	// Sends one byte and lets the stop bit finish before anything is reprogrammed.
	task automatic tx_chk(input logic [7:0] b);
		wr(`UBP_OFS_THR, {24'h0, b});
		pop_chk(b);
		repeat (u_far.bit_clks) @(posedge clk_sys);
	endtask

	task automatic report_and_stop();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock, watchdog and tests
	// ------------------------------------------------------------
	initial forever #5 clk_sys = ~clk_sys;

	// The tests need about thirteen thousand cycles; the limit leaves ample margin.
	initial begin
		repeat (90000) @(posedge clk_sys);
		error_cnt++;
		report_and_stop();
	end

	// Main sequence of register and line scenarios.
	initial begin
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		rd_chk(`UBP_OFS_FD, 32'h0);
		rd_chk(`UBP_OFS_CTRL, 32'hC0);
		rd_chk(`UBP_OFS_HALF_DUPLEX_SELECT, 32'h0);
		rd_chk(8'h44, 32'h0);
		`UBP_CHK(pin_func_sel, 1'b0)
		wr(`UBP_OFS_FD, 32'hFFFF_FFFF);
		rd_chk(`UBP_OFS_FD, 32'h1FF);
		wr(8'h44, 32'h5);
		rd_chk(8'h44, 32'h0);
		wr(`UBP_OFS_CTRL, 32'hC1);
		@(posedge clk_sys);
		`UBP_CHK(pin_func_sel, 1'b1)
		wr(`UBP_OFS_DIV, 32'h4);
		for (int i = 0; i < 5; i++) begin
			wr(`UBP_OFS_FD, fd_tab[i]);
			u_far.bit_clks = bc_tab[i];
			tx_chk(8'hA5 ^ i[7:0]);
		end
		wr(`UBP_OFS_FD, 32'h0);
		u_far.bit_clks = 64;
		wr(`UBP_OFS_THR, 32'h11);
		do rd(`UBP_OFS_STAT, rv); while (rv[1] !== 1'b0);
		wr(`UBP_OFS_THR, 32'h22);
		pop_chk(8'h11);
		pop_chk(8'h22);
		wr(`UBP_OFS_CTRL, 32'h41);
		wr(`UBP_OFS_THR, 32'h5A);
		repeat (2000) @(posedge clk_sys);
		`UBP_CHK(u_far.got_q.size(), 0)
		wr(`UBP_OFS_CTRL, 32'hC1);
		pop_chk(8'h5A);
		wr(`UBP_OFS_THR, 32'h66);
		repeat (200) @(posedge clk_sys);
		wr(`UBP_OFS_CTRL, 32'h41);
		wr(`UBP_OFS_THR, 32'h77);
		pop_chk(8'h66);
		repeat (2000) @(posedge clk_sys);
		`UBP_CHK(u_far.got_q.size(), 0)
		wr(`UBP_OFS_CTRL, 32'hC1);
		pop_chk(8'h77);
		fork
			u_far.send_byte(8'hC3);
			tx_chk(8'h3C);
		join
		rd(`UBP_OFS_STAT, rv);
		`UBP_CHK(rv[0], 1'b1)
		`UBP_CHK(rv[15:8], 8'hC3)
		rd(`UBP_OFS_STAT, rv);
		`UBP_CHK(rv[0], 1'b0)
		wr(`UBP_OFS_CTRL, 32'h81);
		u_far.send_byte(8'h99);
		rd(`UBP_OFS_STAT, rv);
		`UBP_CHK(rv[0], 1'b0)
		wr(`UBP_OFS_CTRL, 32'hC1);
		wr(`UBP_OFS_HALF_DUPLEX_SELECT, 32'h1);
		u_far.send_byte(8'h99);
		rd(`UBP_OFS_STAT, rv);
		`UBP_CHK(rv[0], 1'b0)
		wr(`UBP_OFS_HALF_DUPLEX_SELECT, 32'h0);
		u_far.send_byte(8'h42);
		rd(`UBP_OFS_STAT, rv);
		`UBP_CHK(rv[0], 1'b1)
		`UBP_CHK(rv[15:8], 8'h42)
		report_and_stop();
	end
endmodule

// file: tb/ubp_remote.sv
// Behavioural model of the remote serial device at the far end of the line.
`timescale 1ns/1ps
module ubp_remote (
	input wire logic clk_sys,
	input wire logic line_in,
	output logic line_out
);
	// Bit period in bus clocks, set by the bench to match the programmed baud.
	int bit_clks = 64;
	logic [7:0] got_q[$];

	initial line_out = 1'b1;

	// Receiver: samples mid-bit relative to the start edge, so small tick jitter is tolerated.
	initial forever begin
		logic [7:0] b;
		@(negedge line_in);
		repeat (bit_clks / 2) @(posedge clk_sys);
		if (line_in === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (bit_clks) @(posedge clk_sys);
				b[i] = line_in;
			end
			repeat (bit_clks) @(posedge clk_sys);
			if (line_in === 1'b1) begin
				got_q.push_back(b);
			end
		end
	end

	// Sender: one 8N1 frame, least significant bit first, line idles high afterwards.
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] bits;
		bits = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_sys);
			line_out <= bits[i];
			repeat (bit_clks - 1) @(posedge clk_sys);
		end
	endtask
endmodule
